//--- core/monitor_control_registers.sv
`timescale 1ns/10ps
`default_nettype none
`include "monitor_control_map.svh"

module monitor_control_registers (
  input  wire logic                          i_clk,
  input  wire logic                          i_rstn,
  input  wire logic                          i_ce,
  input  wire monitor_control_pkg::reg_req_t i_req,
  input  wire logic                          i_lock,
  input  wire logic                          i_temp_valid,
  input  wire logic                          i_core_rail_limit,
  input  wire logic                          i_supply_rail_limit,
  input  wire logic                          i_tach_alert,
  input  wire logic                          i_tach_group_en,
  input  wire logic                          i_temp_alert,
  input  wire logic                          i_temp_group_en,
  input  wire logic                          i_fan_speed_input_three_pin_i,
  input  wire logic                          i_pulse_out_two,
  output logic [7:0]                         o_rdata,
  output logic                               o_rvalid,
  output logic                               o_low_power_select,
  output logic                               o_monitor_cycle_select,
  output monitor_control_pkg::avg_counts_t   o_avg_counts,
  output logic                               o_core_rail_enable,
  output logic                               o_supply_rail_enable,
  output logic                               o_spinup_reduce_enable,
  output logic                               o_soft_reset,
  output logic                               o_alert_out_n,
  output logic                               o_fan_speed_input_three,
  output logic                               o_fan_speed_input_three_pin_o,
  output logic                               o_fan_speed_input_three_pin_oe,
  output logic                               o_pulse2_pin_o,
  output logic                               o_pulse2_pin_oe
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------

  // special function control byte
  logic [7:0] special_function_control;
  // voltage alert enable byte
  logic [7:0] voltage_alert_enable;
  // writable part of the configuration byte
  logic [7:0] device_configuration;
  // temperature readings valid, tracked from the engine
  logic       temp_reading_valid;
  // one-cycle soft reset in progress
  logic       soft_reset_pending;

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------

  // write accepted only while unlocked
  logic write_ok;
  // per-register write hits
  logic wr_special;
  logic wr_voltage;
  logic wr_config;
  // host asks for a soft reset
  logic soft_reset_req;

  // gate every write with the lock
  assign write_ok = i_req.wr & ~i_lock; // RULE1

  // address hits
  assign wr_special = write_ok &
                      (i_req.addr == `SPECIAL_FUNCTION_CONTROL_OFS);
  assign wr_voltage = write_ok &
                      (i_req.addr == `VOLTAGE_ALERT_ENABLE_OFS);
  assign wr_config  = write_ok &
                      (i_req.addr == `DEVICE_CONFIGURATION_OFS);

  // writing a one to the trigger bit starts the soft reset
  assign soft_reset_req = wr_config &
                          i_req.wdata[`SOFT_RESET_TRIGGER_BIT]; // RULE16

  // ---------------------------------------------------------------
  // soft reset sequencing
  // ---------------------------------------------------------------

  // the pending flag lives exactly one cycle, then the registers
  // are back at their defaults and the trigger reads zero again
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      soft_reset_pending <= 1'b0;
    end else if (i_ce) begin
      soft_reset_pending <= soft_reset_req & ~soft_reset_pending; // RULE19
    end
  end

  // ---------------------------------------------------------------
  // special function control
  // ---------------------------------------------------------------

  // defaults on power-on or soft reset, else host write
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      special_function_control <= `SPECIAL_FUNCTION_CONTROL_RST; // RULE8
    end else if (i_ce) begin
      if (soft_reset_pending) begin
        // defaults come back; reading registers live elsewhere
        special_function_control <= `SPECIAL_FUNCTION_CONTROL_RST; // RULE17
      end else if (wr_special) begin
        // reserved bits 3 and 4 are stored as written
        special_function_control <= i_req.wdata; // RULE9
      end
    end
  end

  // ---------------------------------------------------------------
  // voltage alert enable
  // ---------------------------------------------------------------

  // reserved bits kept read/write like the rest
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      voltage_alert_enable <= `VOLTAGE_ALERT_ENABLE_RST;
    end else if (i_ce) begin
      if (soft_reset_pending) begin
        voltage_alert_enable <= `VOLTAGE_ALERT_ENABLE_RST; // RULE17
      end else if (wr_voltage) begin
        voltage_alert_enable <= i_req.wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // device configuration
  // ---------------------------------------------------------------

  // bit 3 and bit 7 are never stored here; bits 5 and 6 hold
  // whatever the host wrote
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      device_configuration <= `DEVICE_CONFIGURATION_RST; // RULE15
    end else if (i_ce) begin
      if (soft_reset_pending) begin
        device_configuration <= `DEVICE_CONFIGURATION_RST; // RULE17
      end else if (wr_config) begin
        device_configuration <= i_req.wdata; // RULE18
        // read-only and self-clearing bits stay zero
        device_configuration[`TEMP_READING_VALID_BIT] <= 1'b0;
        device_configuration[`SOFT_RESET_TRIGGER_BIT] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // temperature reading valid flag
  // ---------------------------------------------------------------

  // follows the engine; cleared by either reset
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      temp_reading_valid <= 1'b0; // RULE14
    end else if (i_ce) begin
      if (soft_reset_pending) begin
        temp_reading_valid <= 1'b0; // RULE14
      end else begin
        temp_reading_valid <= i_temp_valid; // RULE14
      end
    end
  end

  // ---------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------

  // assembled configuration view
  logic [7:0] config_view;

  // live status bits merged over the stored byte
  always_comb begin
    config_view = device_configuration;
    config_view[`TEMP_READING_VALID_BIT] = temp_reading_valid; // RULE14
    config_view[`SOFT_RESET_TRIGGER_BIT] = soft_reset_pending; // RULE16
  end

  // registered read data, unmapped offsets read zero
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_rdata  <= 8'h00;
      o_rvalid <= 1'b0;
    end else if (i_ce) begin
      o_rvalid <= i_req.rd;
      if (i_req.rd) begin
        unique case (i_req.addr)
          `SPECIAL_FUNCTION_CONTROL_OFS: begin
            o_rdata <= special_function_control;
          end
          `VOLTAGE_ALERT_ENABLE_OFS: begin
            o_rdata <= voltage_alert_enable;
          end
          `DEVICE_CONFIGURATION_OFS: begin
            o_rdata <= config_view;
          end
          default: begin
            // any other offset belongs to another block
            o_rdata <= 8'h00;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // averaging decode
  // ---------------------------------------------------------------

  // averaging class picked from the select field
  monitor_control_pkg::avg_mode_t avg_mode;
  // counts for the chosen class
  monitor_control_pkg::avg_counts_t next_avg_counts;
  // select field alias
  logic [2:0] averaging_select;

  assign averaging_select =
    special_function_control[`AVERAGING_SELECT_MSB:`AVERAGING_SELECT_LSB];

  // most significant bit wins
  always_comb begin
    if (averaging_select[2]) begin
      avg_mode = monitor_control_pkg::AVG_MAX; // RULE6
    end else if (averaging_select[1]) begin
      avg_mode = monitor_control_pkg::AVG_MID; // RULE7
    end else if (averaging_select[0]) begin
      avg_mode = monitor_control_pkg::AVG_LIGHT; // RULE7
    end else begin
      avg_mode = monitor_control_pkg::AVG_DEEP; // RULE7
    end
  end

  // counts per class: remote diodes, internal diode, voltages
  always_comb begin
    unique case (avg_mode)
      monitor_control_pkg::AVG_DEEP: begin
        next_avg_counts.remote   = `AVG_COUNT_128;
        next_avg_counts.internal = `AVG_COUNT_8;
        next_avg_counts.voltage  = `AVG_COUNT_8;
      end
      monitor_control_pkg::AVG_LIGHT: begin
        next_avg_counts.remote   = `AVG_COUNT_16;
        next_avg_counts.internal = `AVG_COUNT_1;
        next_avg_counts.voltage  = `AVG_COUNT_1;
      end
      monitor_control_pkg::AVG_MID: begin
        next_avg_counts.remote   = `AVG_COUNT_16;
        next_avg_counts.internal = `AVG_COUNT_16;
        next_avg_counts.voltage  = `AVG_COUNT_16;
      end
      monitor_control_pkg::AVG_MAX: begin
        next_avg_counts.remote   = `AVG_COUNT_32;
        next_avg_counts.internal = `AVG_COUNT_32;
        next_avg_counts.voltage  = `AVG_COUNT_32;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // mode and enable outputs
  // ---------------------------------------------------------------

  // registered copies for the measurement engine and fan logic
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_low_power_select     <= 1'b0;
      o_monitor_cycle_select <= 1'b0;
      o_avg_counts.remote    <= `AVG_COUNT_16;
      o_avg_counts.internal  <= `AVG_COUNT_16;
      o_avg_counts.voltage   <= `AVG_COUNT_16;
      o_core_rail_enable     <= 1'b1;
      o_supply_rail_enable   <= 1'b1;
      o_spinup_reduce_enable <= 1'b1;
      o_soft_reset           <= 1'b0;
    end else if (i_ce) begin
      // sleep when clear, deeper low power when set
      o_low_power_select <=
        special_function_control[`LOW_POWER_SELECT_BIT]; // RULE2
      // continuous when clear, cycling when set
      o_monitor_cycle_select <=
        special_function_control[`MONITOR_CYCLE_SELECT_BIT]; // RULE3
      // averages for all six measurements
      o_avg_counts <= next_avg_counts; // RULE5
      // per-channel enables for status and alerts
      o_core_rail_enable <=
        voltage_alert_enable[`CORE_RAIL_CHANNEL_BIT]; // RULE10
      o_supply_rail_enable <=
        voltage_alert_enable[`SUPPLY_RAIL_CHANNEL_BIT]; // RULE10
      // spin-up shortening for the fan logic
      o_spinup_reduce_enable <=
        device_configuration[`SPINUP_REDUCE_ENABLE_BIT]; // RULE15
      // tells the other register blocks to reload defaults
      o_soft_reset <= soft_reset_pending; // RULE17
    end
  end

  // ---------------------------------------------------------------
  // alert combine
  // ---------------------------------------------------------------

  // gated event sources
  logic volt_event;
  logic group_event;
  logic next_alert_n;

  // only enabled rails count
  assign volt_event =
    (i_core_rail_limit &
     voltage_alert_enable[`CORE_RAIL_CHANNEL_BIT]) |
    (i_supply_rail_limit &
     voltage_alert_enable[`SUPPLY_RAIL_CHANNEL_BIT]); // RULE10

  // each group needs its own enable
  assign group_event =
    (volt_event &
     voltage_alert_enable[`VOLTAGE_GROUP_IRQ_ENABLE_BIT]) | // RULE11
    (i_tach_alert & i_tach_group_en) | // RULE20
    (i_temp_alert & i_temp_group_en); // RULE20

  // nothing reaches the pin without the global enable
  assign next_alert_n =
    ~(group_event &
      special_function_control[`GLOBAL_IRQ_ENABLE_BIT]); // RULE4

  // ---------------------------------------------------------------
  // shared pin routing
  // ---------------------------------------------------------------

  // pin select aliases
  logic fan_speed_input_three_as_alert;
  logic pulse2_as_alert;

  assign fan_speed_input_three_as_alert =
    device_configuration[`FAN_SPEED_INPUT_THREE_PIN_ALERT_SELECT_BIT];
  assign pulse2_as_alert =
    device_configuration[`PULSE2_PIN_ALERT_SELECT_BIT];

  // alert is open-drain: enabled only while pulling low
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_alert_out_n           <= 1'b1;
      o_fan_speed_input_three <= 1'b0;
      o_fan_speed_input_three_pin_o           <= 1'b0;
      o_fan_speed_input_three_pin_oe          <= 1'b0;
      o_pulse2_pin_o          <= 1'b0;
      o_pulse2_pin_oe         <= 1'b0;
    end else if (i_ce) begin
      o_alert_out_n <= next_alert_n; // RULE4
      // fan_speed_input_three pin: input when clear, alert output when set
      o_fan_speed_input_three_pin_o  <= 1'b0;
      o_fan_speed_input_three_pin_oe <= fan_speed_input_three_as_alert & ~next_alert_n; // RULE12
      if (fan_speed_input_three_as_alert) begin
        // tach logic sees a quiet input while the pin is taken
        o_fan_speed_input_three <= 1'b0; // RULE12
      end else begin
        o_fan_speed_input_three <= i_fan_speed_input_three_pin_i; // RULE12
      end
      // pulse2 pin: pwm output when clear, alert output when set
      if (pulse2_as_alert) begin
        o_pulse2_pin_o  <= 1'b0; // RULE13
        o_pulse2_pin_oe <= ~next_alert_n; // RULE13
      end else begin
        o_pulse2_pin_o  <= i_pulse_out_two; // RULE13
        o_pulse2_pin_oe <= 1'b1; // RULE13
      end
    end
  end

endmodule

`default_nettype wire

//--- inc/monitor_control_map.svh
// Summary of operation
// RULE1: lock set makes these registers read-only
// RULE2: low_power_select 0 sleep, 1 low power
// RULE3: monitor_cycle_select 0 continuous, 1 cycling
// RULE4: global_irq_enable gates alert_out_n pin function
// RULE5: averaging_select sets averages for six measurements
// RULE6: averaging_select bit 7 forces 32 everywhere
// RULE7: decode 000,001,01x,1xx gives listed averages
// RULE8: averaging_select resets to 010, register 40h
// RULE9: host leaves special bits 3, 4 alone
// RULE10: bits 3 and 7 gate rail channels
// RULE11: voltage group enable needs global enable too
// RULE12: config bit 0 routes alert to fan_speed_input_three pin
// RULE13: config bit 1 routes alert to pulse2 pin
// RULE14: temp_reading_valid read-only, resets to 0
// RULE15: spinup_reduce_enable resets 1, shortens spin-up
// RULE16: config bit 7 write starts self-clearing reset
// RULE17: soft reset restores defaults, keeps readings
// RULE18: host keeps config bits 5, 6 zero
// RULE19: soft reset finishes within one clock
// RULE20: tach and temp groups also need global
`ifndef MONITOR_CONTROL_MAP_SVH
`define MONITOR_CONTROL_MAP_SVH

// register offsets
`define SPECIAL_FUNCTION_CONTROL_OFS 8'h7C
`define VOLTAGE_ALERT_ENABLE_OFS     8'h7E
`define DEVICE_CONFIGURATION_OFS     8'h7F

// reset values
`define SPECIAL_FUNCTION_CONTROL_RST 8'h40
`define VOLTAGE_ALERT_ENABLE_RST     8'hEC
`define DEVICE_CONFIGURATION_RST     8'h10

// special function field positions
`define LOW_POWER_SELECT_BIT     0
`define MONITOR_CYCLE_SELECT_BIT 1
`define GLOBAL_IRQ_ENABLE_BIT    2
`define AVERAGING_SELECT_MSB     7
`define AVERAGING_SELECT_LSB     5

// voltage alert enable field positions
`define VOLTAGE_GROUP_IRQ_ENABLE_BIT 0
`define CORE_RAIL_CHANNEL_BIT        3
`define SUPPLY_RAIL_CHANNEL_BIT      7

// configuration field positions
`define FAN_SPEED_INPUT_THREE_PIN_ALERT_SELECT_BIT  0
`define PULSE2_PIN_ALERT_SELECT_BIT 1
`define TEMP_READING_VALID_BIT      3
`define SPINUP_REDUCE_ENABLE_BIT    4
`define SOFT_RESET_TRIGGER_BIT      7

// averaging counts per reading
`define AVG_COUNT_1   8'h01
`define AVG_COUNT_8   8'h08
`define AVG_COUNT_16  8'h10
`define AVG_COUNT_32  8'h20
`define AVG_COUNT_128 8'h80

`endif

//--- inc/monitor_control_pkg.sv
`default_nettype none
package monitor_control_pkg;

  // one host register access
  typedef struct packed {
    logic       wr;    // write strobe
    logic       rd;    // read strobe
    logic [7:0] addr;  // register offset
    logic [7:0] wdata; // write data
  } reg_req_t;

  // averages applied per measurement class
  typedef struct packed {
    logic [7:0] remote;   // both remote diodes
    logic [7:0] internal; // internal diode
    logic [7:0] voltage;  // all voltage readings
  } avg_counts_t;

  // averaging decode classes
  typedef enum logic [1:0] {
    AVG_DEEP  = 2'b00,
    AVG_LIGHT = 2'b01,
    AVG_MID   = 2'b10,
    AVG_MAX   = 2'b11
  } avg_mode_t;

endpackage
`default_nettype wire

//--- test/monitor_control_registers_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// register block checker
// ------------------------------------------
module monitor_control_registers_sva (
  input wire logic                          i_clk,
  input wire logic                          i_rstn,
  input wire logic                          i_ce,
  input wire monitor_control_pkg::reg_req_t i_req,
  input wire logic                          i_lock,
  input wire logic                          i_core_rail_limit,
  input wire logic                          i_supply_rail_limit,
  input wire logic                          i_tach_alert,
  input wire logic                          i_temp_alert,
  input wire logic                          i_pulse_out_two,
  input wire logic [7:0]                    o_rdata,
  input wire logic                          o_rvalid,
  input wire logic                          o_low_power_select,
  input wire monitor_control_pkg::avg_counts_t o_avg_counts,
  input wire logic                          o_soft_reset,
  input wire logic                          o_spinup_reduce_enable,
  input wire logic                          o_alert_out_n,
  input wire logic                          o_fan_speed_input_three,
  input wire logic                          o_fan_speed_input_three_pin_o,
  input wire logic                          o_fan_speed_input_three_pin_oe,
  input wire logic                          o_pulse2_pin_o,
  input wire logic                          o_pulse2_pin_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  logic [23:0] avg_flat; // averages as one word
  assign avg_flat = o_avg_counts;

  // unlocked write of the reset trigger
  sequence s_init_write;
    i_ce && i_req.wr && !i_lock && i_req.addr == 8'h7F && i_req.wdata[7];
  endsequence

  chk_lock_blocks_write: assert property (
    i_ce && i_req.wr && i_lock && i_req.addr == 8'h7C |=>
    ##1 $stable(o_low_power_select) && $stable(o_avg_counts))
    else $error("locked write changed modes");
  chk_init_pulse_due: assert property (
    s_init_write |-> ##2 o_soft_reset)
    else $error("soft reset pulse missing");
  chk_init_pulse_once: assert property (
    o_soft_reset |=> !o_soft_reset)
    else $error("soft reset pulse too long");
  chk_soft_defaults: assert property (
    o_soft_reset |=> o_spinup_reduce_enable && !o_low_power_select &&
    avg_flat == 24'h101010)
    else $error("defaults not restored");
  chk_avg_legal_set: assert property (
    avg_flat inside {24'h800808, 24'h100101, 24'h101010, 24'h202020})
    else $error("illegal averaging combination");
  chk_alert_idle: assert property (
    !i_core_rail_limit && !i_supply_rail_limit && !i_tach_alert &&
    !i_temp_alert |=> o_alert_out_n)
    else $error("alert without event");
  chk_fan_speed_input_three_pin_alert: assert property (
    o_fan_speed_input_three_pin_oe |-> !o_alert_out_n && !o_fan_speed_input_three_pin_o &&
    !o_fan_speed_input_three)
    else $error("fan_speed_input_three pin driven wrongly");
  chk_pulse2_follow: assert property (
    o_pulse2_pin_o |-> o_pulse2_pin_oe && $past(i_pulse_out_two))
    else $error("pulse2 pin wrong");
  chk_read_answer: assert property (i_ce && i_req.rd |=> o_rvalid)
    else $error("read not answered");
  chk_unmapped_zero: assert property (i_ce && i_req.rd && !(i_req.addr
    inside {8'h7C, 8'h7E, 8'h7F}) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind monitor_control_registers monitor_control_registers_sva sva_inst (
  .i_clk, .i_rstn, .i_ce, .i_req, .i_lock, .i_core_rail_limit,
  .i_supply_rail_limit, .i_tach_alert, .i_temp_alert, .i_pulse_out_two,
  .o_rdata, .o_rvalid, .o_low_power_select, .o_avg_counts, .o_soft_reset,
  .o_spinup_reduce_enable, .o_alert_out_n, .o_fan_speed_input_three,
  .o_fan_speed_input_three_pin_o, .o_fan_speed_input_three_pin_oe, .o_pulse2_pin_o, .o_pulse2_pin_oe
);
`default_nettype wire

//--- test/host_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// host side of the register access
// ------------------------------------------
module host_bus_model (
  input  wire logic                     i_clk,
  input  wire logic [7:0]               i_rdata,
  input  wire logic                     i_rvalid,
  output monitor_control_pkg::reg_req_t o_req
);
  initial o_req = '0;

  // one-cycle write strobe, released lines show the inverse
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    if (a == 8'h7C) d[4:3] = 2'b00;
    if (a == 8'h7F) d[6:5] = 2'b00;
    o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    #1;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // one-cycle read strobe, answer taken one edge later
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic v);
    @(posedge i_clk);
    #1;
    o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk);
    #1;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    d = i_rdata;
    v = i_rvalid;
  endtask
endmodule
`default_nettype wire

//--- test/monitor_control_registers_test.sv
`timescale 1ns/10ps
`default_nettype none
module monitor_control_registers_test;
  logic i_clk, i_rstn, i_ce, i_lock, i_temp_valid;
  logic i_core_rail_limit, i_supply_rail_limit, i_tach_alert;
  logic i_tach_group_en, i_temp_alert, i_temp_group_en;
  logic i_fan_speed_input_three_pin_i, i_pulse_out_two;
  monitor_control_pkg::reg_req_t    i_req;
  monitor_control_pkg::avg_counts_t o_avg_counts;
  logic [7:0] o_rdata;
  logic o_rvalid, o_low_power_select, o_monitor_cycle_select;
  logic o_core_rail_enable, o_supply_rail_enable, o_spinup_reduce_enable;
  logic o_soft_reset, o_alert_out_n, o_fan_speed_input_three;
  logic o_fan_speed_input_three_pin_o, o_fan_speed_input_three_pin_oe, o_pulse2_pin_o, o_pulse2_pin_oe;
  int fail_count = 0;
  int n_checks   = 0;

  monitor_control_registers monitor_control_registers_inst (.*);
  host_bus_model host_bus_model_inst (.i_clk, .i_rdata(o_rdata),
    .i_rvalid(o_rvalid), .o_req(i_req));

  // ------------------------------------------
  // clock, helpers
  // ------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_bus_model_inst.write_reg(a, d);
  endtask

  // read a register and compare
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    host_bus_model_inst.read_reg(a, d, v);
    chk("rvalid", 24'h1, 24'(v));
    chk("rdata", 24'(e), 24'(d));
  endtask

  task automatic settle;
    repeat (2) @(posedge i_clk);
    #1;
  endtask

  // averages expected for each select code
  function automatic logic [23:0] avg_exp(input logic [2:0] s);
    if (s[2]) return 24'h202020;
    if (s[1]) return 24'h101010;
    if (s[0]) return 24'h100101;
    return 24'h800808;
  endfunction

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #(3000 * 100);
    fail_count++;
    print_verdict;
  end

  // ------------------------------------------
  // scenarios
  // ------------------------------------------
  initial begin
    {i_rstn, i_lock, i_temp_valid, i_core_rail_limit} = 4'h0;
    {i_supply_rail_limit, i_tach_alert, i_tach_group_en} = 3'h0;
    {i_temp_alert, i_temp_group_en, i_fan_speed_input_three_pin_i, i_pulse_out_two} = 4'h0;
    i_ce = 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    i_rstn = 1'b1;
    rchk(8'h7C, 8'h40);
    rchk(8'h7E, 8'hEC);
    rchk(8'h7F, 8'h10);
    rchk(8'h7D, 8'h00);
    // every averaging code and both mode bits
    for (int k = 0; k < 8; k++) begin
      wr(8'h7C, {k[2:0], 3'b000, k[1:0]});
      settle;
      chk("avg", avg_exp(k[2:0]), o_avg_counts);
      chk("modes", 24'(k[1:0]), 24'({o_monitor_cycle_select,
        o_low_power_select}));
    end
    // alert gating by global, group and channel enables
    wr(8'h7E, 8'hED);
    wr(8'h7C, 8'h44);
    i_core_rail_limit = 1'b1;
    settle;
    chk("alert", 24'h0, 24'(o_alert_out_n));
    wr(8'h7C, 8'h40);
    settle;
    chk("alert", 24'h1, 24'(o_alert_out_n));
    wr(8'h7C, 8'h44);
    wr(8'h7E, 8'hEC);
    settle;
    chk("alert", 24'h1, 24'(o_alert_out_n));
    wr(8'h7E, 8'h81);
    settle;
    chk("alert", 24'h1, 24'(o_alert_out_n));
    chk("rails", 24'h1,
      24'({o_core_rail_enable, o_supply_rail_enable}));
    {i_core_rail_limit, i_supply_rail_limit} = 2'b01;
    settle;
    chk("alert", 24'h0, 24'(o_alert_out_n));
    {i_supply_rail_limit, i_tach_alert, i_tach_group_en} = 3'b011;
    settle;
    chk("alert", 24'h0, 24'(o_alert_out_n));
    wr(8'h7C, 8'h40);
    settle;
    chk("alert", 24'h1, 24'(o_alert_out_n));
    {i_tach_alert, i_temp_alert, i_temp_group_en} = 3'b011;
    wr(8'h7C, 8'h44);
    wr(8'h7F, 8'h13);
    settle;
    chk("alert", 24'h0, 24'(o_alert_out_n));
    chk("pins", 24'h14, 24'({o_fan_speed_input_three_pin_oe, o_fan_speed_input_three_pin_o, o_pulse2_pin_oe,
      o_pulse2_pin_o, o_fan_speed_input_three}));
    {i_temp_alert, i_fan_speed_input_three_pin_i, i_pulse_out_two} = 3'b011;
    wr(8'h7F, 8'h10);
    settle;
    chk("pins", 24'h07, 24'({o_fan_speed_input_three_pin_oe, o_fan_speed_input_three_pin_o, o_pulse2_pin_oe,
      o_pulse2_pin_o, o_fan_speed_input_three}));
    // locked writes are dropped
    wr(8'h7C, 8'h40);
    i_lock = 1'b1;
    wr(8'h7C, 8'hE7);
    wr(8'h7F, 8'h80);
    rchk(8'h7C, 8'h40);
    rchk(8'h7F, 8'h10);
    i_lock = 1'b0;
    // ready flag ignores writes, follows the engine
    wr(8'h7F, 8'h18);
    rchk(8'h7F, 8'h10);
    i_temp_valid = 1'b1;
    settle;
    rchk(8'h7F, 8'h18);
    i_temp_valid = 1'b0;
    // soft reset restores all three registers
    wr(8'h7C, 8'hA7);
    wr(8'h7E, 8'h00);
    wr(8'h7F, 8'h03);
    settle;
    chk("spinup", 24'h0, 24'(o_spinup_reduce_enable));
    wr(8'h7F, 8'h83);
    rchk(8'h7F, 8'h10);
    rchk(8'h7C, 8'h40);
    rchk(8'h7E, 8'hEC);
    chk("spinup", 24'h1, 24'(o_spinup_reduce_enable));
    // a low clock enable freezes every register, writes included
    i_ce = 1'b0;
    wr(8'h7C, 8'h47);
    chk("frozen", 24'h0, 24'(o_low_power_select));
    i_ce = 1'b1;
    rchk(8'h7C, 8'h40);
    print_verdict;
  end
endmodule
`default_nettype wire
